// ---- logic/timer_two_pkg.sv ----
package timer_two_pkg;

	// Register byte offsets on the AXI4-Lite port.
	localparam int             ADDR_W            = 12;
	localparam logic [11:0]    CTRL_OFFSET       = 12'h418;
	localparam logic [11:0]    RELOAD_OFFSET     = 12'h41c;
	localparam logic [11:0]    CAPTURE_OFFSET    = 12'h420;
	localparam logic [11:0]    COUNT_OFFSET      = 12'h424;
	localparam logic [11:0]    AUX_OFFSET        = 12'h428;
	localparam logic [11:0]    IRQ_STATUS_OFFSET = 12'h42c;
	localparam logic [11:0]    IRQ_MASK_OFFSET   = 12'h430;

	// Field positions in the control register.
	localparam int             OVF_FLAG_BIT      = 7;
	localparam int             EXT_FLAG_BIT      = 6;
	localparam int             RX_SEL_BIT        = 5;
	localparam int             TX_SEL_BIT        = 4;
	localparam int             EXT_EN_BIT        = 3;
	localparam int             RUN_BIT           = 2;
	localparam int             SRC_SEL_BIT       = 1;
	localparam int             CAP_SEL_BIT       = 0;

	// Field positions in the auxiliary configuration register.
	localparam int             SECOND_RX_BIT     = 0;
	localparam int             SECOND_TX_BIT     = 1;
	localparam int             CLK_OUT_EN_BIT    = 2;

	// Event positions in the interrupt status and mask registers.
	localparam int             IRQ_W             = 2;
	localparam int             IRQ_OVF_BIT       = 0;
	localparam int             IRQ_EXT_BIT       = 1;

	// Values after reset, and the counter's top value.
	localparam logic [7:0]     CTRL_RESET        = 8'h00;
	localparam logic [2:0]     AUX_RESET         = 3'h0;
	localparam logic [15:0]    COUNT_RESET       = 16'h0000;
	localparam logic [15:0]    COUNT_MAX         = 16'hffff;
	localparam logic [IRQ_W-1:0] IRQ_RESET       = 2'h0;
	localparam logic           PIN_IDLE          = 1'b1;

	// AXI response codes.
	localparam logic [1:0]     RESP_OKAY         = 2'h0;
	localparam logic [1:0]     RESP_SLVERR       = 2'h2;

endpackage : timer_two_pkg

// ---- logic/falling_edge_detect.sv ----
`timescale 1ns/1ps

module falling_edge_detect
	import timer_two_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic level,
	output wire logic fall
);

	logic prev_q;

	// Idle-high reset value makes a pin that is low at release show as a falling edge in the first cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= PIN_IDLE;
		end else begin
			prev_q <= level;
		end
	end

	assign fall = prev_q & ~level;

endmodule : falling_edge_detect

// ---- logic/timer_two_control_logic.sv ----
`timescale 1ns/1ps

// Summary of operation
// - Overflow sets sticky overflow flag; software clears.
// - No overflow flag in baud or clock-out.
// - Trigger-pin capture or reload sets event flag.
// - Event flag raises interrupt when enabled.
// - Capture select plus trigger enable: capture edges.
// - Reload select plus trigger enable: reload both.
// - Baud mode reloads on overflow only.
// - Capture copies counter bytes into capture bytes.
// - Reload loads counter from preset reload value.
// - Counter advances only while run is set.
// - Baud selects route overflow to serial ticks.
module timer_two_control_logic
	import timer_two_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic [2:0]    awprot,
	input  wire logic          awvalid,
	output wire logic          awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output wire logic          wready,
	output wire logic [1:0]    bresp,
	output wire logic          bvalid,
	input  wire logic          bready,
	input  wire logic [AW-1:0] araddr,
	input  wire logic [2:0]    arprot,
	input  wire logic          arvalid,
	output wire logic          arready,
	output wire logic [31:0]   rdata,
	output wire logic [1:0]    rresp,
	output wire logic          rvalid,
	input  wire logic          rready,
	input  wire logic          ext_count_pin,
	input  wire logic          external_trigger_pin,
	output wire logic          timer_irq,
	output wire logic          tx_baud_tick,
	output wire logic          rx_baud_tick
);

	// Bus handshake state.
	logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic                aw_hold_q, w_hold_q;
	logic [AW-1:0]       awaddr_q;
	logic [31:0]         wdata_q, rdata_q;
	logic [3:0]          wstrb_q;
	logic [1:0]          bresp_q, rresp_q;
	logic                aw_take, w_take, ar_take, wr_fire;
	// Timer state.
	logic [7:0]          ctrl_q;
	logic [2:0]          aux_q;
	logic [15:0]         count_q, reload_q, capture_q;
	logic [IRQ_W-1:0]    irq_status_q, irq_mask_q, irq_set;
	logic                timer_irq_q, tx_tick_q, rx_tick_q;
	// Decoded events.
	logic                count_fall, trig_fall, baud_mode, advance;
	logic                overflow_evt, trig_evt, capture_evt, reload_evt, ovf_set;
	logic                wr_ctrl, wr_reload, wr_count, wr_aux, wr_status, wr_mask;
	logic                wr_hit;

	falling_edge_detect u_count_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (ext_count_pin),
		.fall    (count_fall)
	);

	falling_edge_detect u_trig_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (external_trigger_pin),
		.fall    (trig_fall)
	);

	// Merge a write into a 16-bit register one byte lane at a time.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// Read multiplexer; narrower registers read zero in the upper bits.
	function automatic logic [31:0] read_mux(input logic [AW-1:0] a);
		case (a)
			CTRL_OFFSET:       read_mux = {24'h000000, ctrl_q};
			RELOAD_OFFSET:     read_mux = {16'h0000, reload_q};
			CAPTURE_OFFSET:    read_mux = {16'h0000, capture_q};
			COUNT_OFFSET:      read_mux = {16'h0000, count_q};
			AUX_OFFSET:        read_mux = {29'h00000000, aux_q};
			IRQ_STATUS_OFFSET: read_mux = {30'h00000000, irq_status_q};
			IRQ_MASK_OFFSET:   read_mux = {30'h00000000, irq_mask_q};
			default:           read_mux = 32'h00000000;
		endcase
	endfunction : read_mux

	// A write goes ahead once both halves are held and the last answer has been taken.
	assign aw_take = awvalid & awready_q;
	assign w_take  = wvalid & wready_q;
	assign ar_take = arvalid & arready_q;
	assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;

	// Write address and data are taken independently and held until the write fires.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
		end else begin
			aw_hold_q <= aw_take | (aw_hold_q & ~wr_fire);
			w_hold_q  <= w_take | (w_hold_q & ~wr_fire);
			awready_q <= ~(aw_take | (aw_hold_q & ~wr_fire));
			wready_q  <= ~(w_take | (w_hold_q & ~wr_fire));
			if (aw_take) begin
				awaddr_q <= awaddr;
			end
			if (w_take) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
		end
	end

	// Write response stands until the master takes it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			bvalid_q <= wr_fire | (bvalid_q & ~bready);
			if (wr_fire) begin
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Reads answer one cycle after the address is taken; no new address while data waits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= RESP_OKAY;
		end else begin
			arready_q <= ~(ar_take | (rvalid_q & ~rready));
			rvalid_q  <= ar_take | (rvalid_q & ~rready);
			if (ar_take) begin
				rdata_q <= read_mux(araddr);
				rresp_q <= (read_mux(araddr) == 32'h00000000 &&
					!(araddr inside {CTRL_OFFSET, RELOAD_OFFSET, CAPTURE_OFFSET,
					COUNT_OFFSET, AUX_OFFSET, IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET}))
					? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// Write decode.
	assign wr_ctrl   = wr_fire & (awaddr_q == CTRL_OFFSET) & wstrb_q[0];
	assign wr_reload = wr_fire & (awaddr_q == RELOAD_OFFSET);
	assign wr_count  = wr_fire & (awaddr_q == COUNT_OFFSET);
	assign wr_aux    = wr_fire & (awaddr_q == AUX_OFFSET) & wstrb_q[0];
	assign wr_status = wr_fire & (awaddr_q == IRQ_STATUS_OFFSET) & wstrb_q[0];
	assign wr_mask   = wr_fire & (awaddr_q == IRQ_MASK_OFFSET) & wstrb_q[0];
	assign wr_hit    = awaddr_q inside {CTRL_OFFSET, RELOAD_OFFSET, CAPTURE_OFFSET,
		COUNT_OFFSET, AUX_OFFSET, IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET};

	// Baud selection overrides the capture/reload choice entirely.
	assign baud_mode = ctrl_q[RX_SEL_BIT] | ctrl_q[TX_SEL_BIT];
	assign advance = ctrl_q[RUN_BIT] & (ctrl_q[SRC_SEL_BIT] ? count_fall : 1'b1);
	assign overflow_evt = advance & (count_q == COUNT_MAX);
	assign trig_evt = trig_fall & ctrl_q[EXT_EN_BIT] & ~baud_mode;
	assign capture_evt = trig_evt & ctrl_q[CAP_SEL_BIT];
	assign reload_evt = (overflow_evt & (baud_mode | ~ctrl_q[CAP_SEL_BIT])) |
		(trig_evt & ~ctrl_q[CAP_SEL_BIT]);
	// Flag suppressed by baud or clock-out
	assign ovf_set = overflow_evt & ~baud_mode & ~aux_q[SECOND_RX_BIT] &
		~aux_q[SECOND_TX_BIT] & ~aux_q[CLK_OUT_EN_BIT];

	// Counter; a software write takes priority over a same-cycle count or reload.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= COUNT_RESET;
		end else if (wr_count) begin
			count_q <= merge16(count_q, wdata_q, wstrb_q);
		end else if (reload_evt) begin
			count_q <= reload_q;
		end else if (advance) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// Reload preset and capture snapshot.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_q  <= COUNT_RESET;
			capture_q <= COUNT_RESET;
		end else begin
			if (wr_reload) begin
				reload_q <= merge16(reload_q, wdata_q, wstrb_q);
			end
			if (capture_evt) begin
				capture_q <= count_q;
			end
		end
	end

	// Control register; hardware setting a flag wins over a same-cycle software clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			aux_q  <= AUX_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wdata_q[7:0];
			end
			if (ovf_set) begin
				ctrl_q[OVF_FLAG_BIT] <= 1'b1;
			end
			if (trig_evt) begin
				ctrl_q[EXT_FLAG_BIT] <= 1'b1;
			end
			if (wr_aux) begin
				aux_q <= wdata_q[2:0];
			end
		end
	end

	assign irq_set[IRQ_OVF_BIT] = ovf_set;
	assign irq_set[IRQ_EXT_BIT] = trig_evt;

	// Sticky status bits, cleared by writing one; a new event in the same cycle survives.
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++) begin : g_status
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					irq_status_q[gi] <= 1'b0;
				end else if (irq_set[gi]) begin
					irq_status_q[gi] <= 1'b1;
				end else if (wr_status && wdata_q[gi]) begin
					irq_status_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mask register and the registered interrupt level.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q  <= IRQ_RESET;
			timer_irq_q <= 1'b0;
		end else begin
			if (wr_mask) begin
				irq_mask_q <= wdata_q[IRQ_W-1:0];
			end
			timer_irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	// Overflow pulses to the first serial port; one cycle per overflow.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_tick_q <= 1'b0;
			rx_tick_q <= 1'b0;
		end else begin
			tx_tick_q <= overflow_evt & ctrl_q[TX_SEL_BIT];
			rx_tick_q <= overflow_evt & ctrl_q[RX_SEL_BIT];
		end
	end

	assign awready      = awready_q;
	assign wready       = wready_q;
	assign bvalid       = bvalid_q;
	assign bresp        = bresp_q;
	assign arready      = arready_q;
	assign rvalid       = rvalid_q;
	assign rdata        = rdata_q;
	assign rresp        = rresp_q;
	assign timer_irq    = timer_irq_q;
	assign tx_baud_tick = tx_tick_q;
	assign rx_baud_tick = rx_tick_q;

endmodule : timer_two_control_logic

// ---- tb/timer_two_properties.sv ----
`timescale 1ns/1ps

// Port-level relations of the register bus and the interrupt line.
module timer_two_properties
	import timer_two_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic [AW-1:0] awaddr,
	input wire logic          awvalid,
	input wire logic          awready,
	input wire logic          wvalid,
	input wire logic          wready,
	input wire logic [1:0]    bresp,
	input wire logic          bvalid,
	input wire logic          bready,
	input wire logic [AW-1:0] araddr,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic [31:0]   rdata,
	input wire logic [1:0]    rresp,
	input wire logic          rvalid,
	input wire logic          rready,
	input wire logic          timer_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read not answered next cycle");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
		else $error("write not answered in time");
	a_read_slverr: assert property (arvalid && arready && araddr == 12'h400 |=>
		rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read not refused");
	a_read_okay: assert property (arvalid && arready && araddr == CTRL_OFFSET |=>
		rresp == RESP_OKAY) else $error("control read refused");
	a_write_slverr: assert property (awvalid && awready && wvalid && wready &&
		awaddr == 12'h400 |=> ##1 bresp == RESP_SLVERR) else $error("unmapped write not refused");
	a_irq_sticky: assert property (timer_irq && !bvalid && !wvalid && !awvalid |=> timer_irq)
		else $error("interrupt dropped without a write");
endmodule : timer_two_properties

bind timer_two_control_logic timer_two_properties #(.AW(AW)) timer_two_properties_inst (
	.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready), .timer_irq(timer_irq)
);

// ---- tb/timer_two_control_logic_bench.sv ----
`timescale 1ns/1ps

module timer_two_control_logic_bench;
	import timer_two_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        ext_count_pin = PIN_IDLE, external_trigger_pin = PIN_IDLE;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rd, keep;
	logic [1:0]  rs;
	wire logic   awready, wready, bvalid, arready, rvalid, timer_irq, tx_baud_tick, rx_baud_tick;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          err_count = 0, samples_checked = 0, cycles = 0, rx_n = 0, tx_n = 0, n, m;

	// Free-running bus clock.
	always #20 aclk = ~aclk;

	timer_two_control_logic timer_two_control_logic_inst (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ext_count_pin(ext_count_pin), .external_trigger_pin(external_trigger_pin),
		.timer_irq(timer_irq), .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick)
	);

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// Counts baud ticks and cuts a hang short; the whole run needs a few hundred cycles.
	always @(posedge aclk) begin
		cycles++;
		if (rx_baud_tick === 1'b1) rx_n++;
		if (tx_baud_tick === 1'b1) tx_n++;
		if (cycles == 20000) begin
			err_count++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wait_n(input int k);
		repeat (k) @(posedge aclk);
	endtask : wait_n

	// Address and data go out together; each is released once taken.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd_reg(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rd = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd_reg

	// One falling edge on the trigger pin or on the count pin, held long enough to be seen.
	task automatic fall(input bit trig);
		@(posedge aclk);
		if (trig) external_trigger_pin <= 1'b0;
		else ext_count_pin <= 1'b0;
		wait_n(2);
		external_trigger_pin <= 1'b1;
		ext_count_pin <= 1'b1;
		wait_n(2);
	endtask : fall

	task automatic t_reset();
		rd_reg(CTRL_OFFSET);
		check(rd, {24'h0, CTRL_RESET});
		rd_reg(12'h400);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(12'h400, 32'hff);
		check({30'h0, rs}, {30'h0, RESP_SLVERR});
		$display("t_reset done");
	endtask : t_reset

	task automatic t_run();
		wr(RELOAD_OFFSET, 32'h1234);
		wr(COUNT_OFFSET, 32'hfff0);
		wait_n(5);
		rd_reg(COUNT_OFFSET);
		check(rd, 32'hfff0);
		wr(CTRL_OFFSET, 32'h04);
		wait_n(40);
		// The flag must come from the overflow itself, before software touches it.
		rd_reg(CTRL_OFFSET);
		check(rd, 32'h84);
		wr(CTRL_OFFSET, 32'h80);
		rd_reg(CTRL_OFFSET);
		check(rd, 32'h80);
		rd_reg(COUNT_OFFSET);
		check({24'h0, rd[15:8]}, 32'h12);
		keep = rd;
		wait_n(10);
		rd_reg(COUNT_OFFSET);
		check(rd, keep);
		check({31'h0, timer_irq}, 32'h0);
		wr(CTRL_OFFSET, 32'h00);
		rd_reg(CTRL_OFFSET);
		check(rd, 32'h00);
		wr(IRQ_STATUS_OFFSET, 32'h3);
		$display("t_run done");
	endtask : t_run

	task automatic t_capture();
		wr(IRQ_MASK_OFFSET, 32'h2);
		wr(COUNT_OFFSET, 32'h5a5a);
		wr(CTRL_OFFSET, 32'h09);
		fall(1);
		rd_reg(CAPTURE_OFFSET);
		check(rd, 32'h5a5a);
		rd_reg(CTRL_OFFSET);
		check(rd, 32'h49);
		check({31'h0, timer_irq}, 32'h1);
		wr(CTRL_OFFSET, 32'h00);
		wr(IRQ_STATUS_OFFSET, 32'h2);
		wait_n(2);
		check({31'h0, timer_irq}, 32'h0);
		$display("t_capture done");
	endtask : t_capture

	task automatic t_reload();
		wr(RELOAD_OFFSET, 32'hbeef);
		wr(COUNT_OFFSET, 32'h0010);
		wr(CTRL_OFFSET, 32'h08);
		fall(1);
		rd_reg(COUNT_OFFSET);
		check(rd, 32'hbeef);
		rd_reg(CTRL_OFFSET);
		check(rd, 32'h48);
		wr(CTRL_OFFSET, 32'h00);
		wr(IRQ_STATUS_OFFSET, 32'h2);
		$display("t_reload done");
	endtask : t_reload

	task automatic t_baud();
		wr(RELOAD_OFFSET, 32'hfff8);
		wr(COUNT_OFFSET, 32'hfff8);
		wr(CTRL_OFFSET, 32'h2d);
		n = rx_n;
		m = tx_n;
		wait_n(64);
		check({31'h0, (rx_n - n >= 7 && rx_n - n <= 9)}, 32'h1);
		check(tx_n, m);
		fall(1);
		rd_reg(CAPTURE_OFFSET);
		check(rd, 32'h5a5a);
		rd_reg(CTRL_OFFSET);
		check(rd, 32'h2d);
		// Transmit side alone; snapshot after the last receive tick has been counted.
		wr(CTRL_OFFSET, 32'h1d);
		wait_n(2);
		n = rx_n;
		m = tx_n;
		wait_n(64);
		check({31'h0, (tx_n - m >= 7 && tx_n - m <= 9)}, 32'h1);
		check(rx_n, n);
		rd_reg(CTRL_OFFSET);
		check(rd, 32'h1d);
		wr(CTRL_OFFSET, 32'h00);
		// Each auxiliary select alone must keep the overflow flag clear.
		for (int k = 0; k < 3; k++) begin
			wr(AUX_OFFSET, 32'h1 << k);
			wr(COUNT_OFFSET, 32'hfffc);
			wr(CTRL_OFFSET, 32'h04);
			wait_n(20);
			rd_reg(CTRL_OFFSET);
			check(rd, 32'h04);
			wr(CTRL_OFFSET, 32'h00);
		end
		wr(AUX_OFFSET, 32'h0);
		$display("t_baud done");
	endtask : t_baud

	task automatic t_source();
		wr(COUNT_OFFSET, 32'h0);
		wr(CTRL_OFFSET, 32'h06);
		wait_n(10);
		rd_reg(COUNT_OFFSET);
		check(rd, 32'h0);
		repeat (5) fall(0);
		rd_reg(COUNT_OFFSET);
		check(rd, 32'h5);
		wr(CTRL_OFFSET, 32'h00);
		$display("t_source done");
	endtask : t_source

	// Reset for four cycles, then each scenario in turn.
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_run();
		t_capture();
		t_reload();
		t_baud();
		t_source();
		test_done();
	end
endmodule : timer_two_control_logic_bench
